// *** hw/pwm_gate_pkg.sv ***
package pwm_gate_pkg;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] ctrl_off      = 8'h00;
    localparam logic [7:0] gate_off      = 8'h04;
    localparam logic [7:0] polarity_off  = 8'h08;
    localparam logic [7:0] fault_cfg_off = 8'h0c;
    localparam logic [7:0] fault_sts_off = 8'h10;
    localparam logic [7:0] trig_cfg_off  = 8'h14;
    localparam logic [7:0] init_off      = 8'h18;
    localparam logic [7:0] counter_off   = 8'h1c;
    localparam logic [7:0] init_val_off  = 8'h20;
    // ----------------------------------------
    // ctrl fields
    // ----------------------------------------
    localparam int ctrl_enh_pos    = 0;
    localparam int ctrl_fmode_pos  = 1;
    localparam int ctrl_sync_pos   = 3;
    localparam int ctrl_fie_pos    = 4;
    localparam int ctrl_rte_pos    = 5;
    localparam int ctrl_counter_clock_select_pos   = 6;
    localparam int ctrl_comb_pos   = 8;
    localparam int ctrl_pfen_pos   = 12;
    // ----------------------------------------
    // fault config / status fields
    // ----------------------------------------
    localparam int fcfg_en_pos     = 0;
    localparam int fcfg_flt_pos    = 4;
    localparam int fcfg_len_pos    = 8;
    localparam int fsts_flag_pos   = 0;
    localparam int fsts_any_pos    = 4;
    localparam int fsts_lvl_pos    = 5;
    localparam int fsts_irq_pos    = 6;
    // ----------------------------------------
    // init register fields
    // ----------------------------------------
    localparam int init_cmd_pos    = 8;
    // ----------------------------------------
    // reset values and modes
    // ----------------------------------------
    localparam logic [31:0] reset_word     = 32'h0000_0000;
    localparam logic [1:0]  fmode_off      = 2'h0;
    localparam logic [1:0]  fmode_auto     = 2'h3;
    localparam logic [4:0]  bypass_stages  = 5'h2;
endpackage : pwm_gate_pkg

// *** hw/pwm_output_fault_control.sv ***
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - mask bit one drives channel to inactive level given by its polarity
// - mask writes go to a buffer; visible mask loads per sync setting
// - masking acts before polarity inversion; inactive stays inactive
// - masking, fault forcing, polarity, init and triggers act only in combined mode
// - fault handling only with enhanced enable and nonzero fault mode
// - four fault inputs, each with input and filter enable; shared length
// - inputs synchronised then filtered; 5-bit counter restarts on change
// - reverting input restarts counter; short pulses never reach edge detector
// - bypassed path delays two edges; flag sets on third edge
// - filtered path delays three plus length; flag sets four plus length
// - rising edge on enabled input sets its flag; any flag is OR of four
// - fault edge with pair enable forces pair outputs to polarity values
// - interrupt while any flag and irq enable; cleared by read-one-write-zero
// - automatic mode re-enables outputs when level low and new cycle starts
// - manual mode re-enables outputs after flag cleared and new cycle starts
// - polarity zero active-high, one active-low
// - init command loads each output with its init value
// - enhanced mode: selected channel matches pulse shared trigger
// - reload trigger enable emits trigger when counter loads initial value
// - also trigger when counter at initial, clock stopped, nonzero clock select written
// - sync off: mask next edge; sync on: mask loads at sync trigger
module pwm_output_fault_control
#(
    parameter int channels = 6,
    parameter int faults   = 4
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_reset_n,
    input  wire logic                i_psel,
    input  wire logic                i_penable,
    input  wire logic                i_pwrite,
    input  wire logic [7:0]          i_paddr,
    input  wire logic [31:0]         i_pwdata,
    output logic      [31:0]         o_prdata,
    output logic                     o_pready,
    output logic                     o_pslverr,
    input  wire logic [channels-1:0] i_pwm_raw,
    input  wire logic [channels-1:0] i_channel_match,
    input  wire logic [faults-1:0]   i_fault_pin,
    input  wire logic                i_cycle_start,
    input  wire logic                i_counter_reload,
    input  wire logic                i_counter_byte_write,
    input  wire logic                i_counter_sync,
    input  wire logic                i_gate_sync_trigger,
    input  wire logic                i_counter_at_initial,
    output logic      [channels-1:0] o_channel_out,
    output logic                     o_fault_irq,
    output logic                     o_match_trigger,
    output logic                     o_reload_trigger
);
    import pwm_gate_pkg::*;

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [31:0]         ctrl_reg;
    logic [channels-1:0] gate_buf_reg;
    logic [channels-1:0] output_gate_register;
    logic [channels-1:0] polarity_reg;
    logic [channels-1:0] init_value_reg;
    logic [channels-1:0] trig_sel_reg;
    logic [faults-1:0]   fault_input_enable;
    logic [faults-1:0]   fault_filter_enable;
    logic [3:0]          fault_filter_length;
    logic [faults-1:0]   fault_input_flag;
    logic                any_read_one_reg;
    logic                init_cmd_reg;
    logic wr_en;
    logic rd_en;
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign rd_en = i_psel && i_penable && !i_pwrite;
    logic                enhanced_features_enable;
    logic [1:0]          fault_handling_mode;
    logic                gate_sync_enable;
    logic                fault_irq_enable;
    logic                reload_trigger_enable;
    logic [1:0]          counter_clock_select;
    logic [2:0]          combine_pair;
    logic [2:0]          pair_fault_enable;
    assign enhanced_features_enable = ctrl_reg[ctrl_enh_pos];
    assign fault_handling_mode      = ctrl_reg[ctrl_fmode_pos +: 2];
    assign gate_sync_enable         = ctrl_reg[ctrl_sync_pos];
    assign fault_irq_enable         = ctrl_reg[ctrl_fie_pos];
    assign reload_trigger_enable    = ctrl_reg[ctrl_rte_pos];
    assign counter_clock_select     = ctrl_reg[ctrl_counter_clock_select_pos +: 2];
    assign combine_pair             = ctrl_reg[ctrl_comb_pos +: 3];
    assign pair_fault_enable        = ctrl_reg[ctrl_pfen_pos +: 3];
    logic fault_ctrl_on;
    assign fault_ctrl_on = enhanced_features_enable && (fault_handling_mode != fmode_off);
    logic any_combined;
    assign any_combined = |combine_pair;
    function automatic logic in_comb(input logic [2:0] comb, input int ch);
        in_comb = comb[ch/2];
    endfunction : in_comb

    // ----------------------------------------
    // control register and mask buffer
    // ----------------------------------------
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_reg       <= reset_word;
            polarity_reg   <= '0;
            init_value_reg <= '0;
            trig_sel_reg   <= '0;
            gate_buf_reg   <= '0;
        end else if (wr_en) begin
            case (i_paddr)
                ctrl_off:     ctrl_reg       <= i_pwdata;
                polarity_off: polarity_reg   <= i_pwdata[channels-1:0];
                init_off:     init_value_reg <= i_pwdata[channels-1:0];
                trig_cfg_off: trig_sel_reg   <= i_pwdata[channels-1:0];
                gate_off:     gate_buf_reg   <= i_pwdata[channels-1:0];
                default: ;
            endcase
        end
    end

    // buffered value only becomes visible per sync setting
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            output_gate_register <= '0;
        end else if (!gate_sync_enable || i_gate_sync_trigger) begin
            output_gate_register <= gate_buf_reg;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fault_input_enable  <= '0;
            fault_filter_enable <= '0;
            fault_filter_length <= '0;
        end else if (wr_en && i_paddr == fault_cfg_off) begin
            fault_input_enable  <= i_pwdata[fcfg_en_pos +: faults];
            fault_filter_enable <= i_pwdata[fcfg_flt_pos +: faults];
            fault_filter_length <= i_pwdata[fcfg_len_pos +: 4];
        end
    end

    // ----------------------------------------
    // fault synchroniser and filter
    // ----------------------------------------
    logic [faults-1:0] sync1_reg;
    logic [faults-1:0] sync2_reg;
    logic [faults-1:0] filt_reg;
    logic [faults-1:0] edge_src_reg;
    logic [4:0]        filt_cnt_reg [faults];

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= i_fault_pin;
            sync2_reg <= sync1_reg;
        end
    end

    // counter restarts on any change, so glitches never propagate
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            filt_reg <= '0;
            for (int k = 0; k < faults; k++) filt_cnt_reg[k] <= '0;
        end else begin
            for (int k = 0; k < faults; k++) begin
                if (sync2_reg[k] == filt_reg[k]) begin
                    filt_cnt_reg[k] <= '0;
                end else if (filt_cnt_reg[k] >= {1'b0, fault_filter_length}) begin
                    filt_reg[k]     <= sync2_reg[k];
                    filt_cnt_reg[k] <= '0;
                end else begin
                    filt_cnt_reg[k] <= filt_cnt_reg[k] + 5'h1;
                end
            end
        end
    end

    logic [faults-1:0] filter_on;
    logic [faults-1:0] fault_level;
    always_comb begin
        for (int k = 0; k < faults; k++) begin
            filter_on[k]   = fault_filter_enable[k] && fault_input_enable[k] &&
                             (fault_filter_length != 4'h0);
            fault_level[k] = filter_on[k] ? filt_reg[k] : sync2_reg[k];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            edge_src_reg <= '0;
        end else begin
            edge_src_reg <= fault_level;
        end
    end

    logic [faults-1:0] fault_rise;
    assign fault_rise = fault_level & ~edge_src_reg & fault_input_enable & {faults{fault_ctrl_on}};

    // ----------------------------------------
    // fault flags, set wins over clear
    // ----------------------------------------
    logic fault_any_flag;
    logic fault_level_status;
    assign fault_any_flag     = |fault_input_flag;
    assign fault_level_status = |(fault_level & fault_input_enable);
    logic clear_write;
    assign clear_write = wr_en && i_paddr == fault_sts_off && any_read_one_reg &&
                         !i_pwdata[fsts_any_pos];

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fault_input_flag <= '0;
        end else begin
            fault_input_flag <= (clear_write ? '0 : fault_input_flag) | fault_rise;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            any_read_one_reg <= 1'b0;
        end else if (rd_en && i_paddr == fault_sts_off) begin
            any_read_one_reg <= fault_any_flag;
        end else if (clear_write) begin
            any_read_one_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_fault_irq <= 1'b0;
        end else begin
            o_fault_irq <= fault_any_flag && fault_irq_enable;
        end
    end

    // ----------------------------------------
    // safe state per pair
    // ----------------------------------------
    logic [2:0] pair_safe_reg;
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pair_safe_reg <= '0;
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (fault_ctrl_on && pair_fault_enable[p] && combine_pair[p] && |fault_rise) begin
                    pair_safe_reg[p] <= 1'b1;
                end else if (!fault_ctrl_on) begin
                    pair_safe_reg[p] <= 1'b0;
                end else if (i_cycle_start && fault_handling_mode == fmode_auto &&
                             !fault_level_status) begin
                    pair_safe_reg[p] <= 1'b0;
                end else if (i_cycle_start && fault_handling_mode != fmode_auto &&
                             !fault_any_flag) begin
                    pair_safe_reg[p] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // init command and output path
    // ----------------------------------------
    // one-shot; software should only use it with the counter stopped
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            init_cmd_reg <= 1'b0;
        end else begin
            init_cmd_reg <= wr_en && i_paddr == init_off && i_pwdata[init_cmd_pos];
        end
    end

    logic [channels-1:0] init_hold_reg;
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_channel_out <= '0;
            init_hold_reg <= '0;
        end else begin
            for (int c = 0; c < channels; c++) begin
                if (!in_comb(combine_pair, c)) begin
                    o_channel_out[c] <= i_pwm_raw[c];
                    init_hold_reg[c] <= 1'b0;
                end else if (pair_safe_reg[c/2]) begin
                    o_channel_out[c] <= polarity_reg[c];
                end else if (init_cmd_reg) begin
                    o_channel_out[c] <= init_value_reg[c];
                    init_hold_reg[c] <= 1'b1;
                end else if (init_hold_reg[c] && i_pwm_raw[c] == o_channel_out[c]) begin
                    init_hold_reg[c] <= 1'b0;
                end else if (!init_hold_reg[c]) begin
                    // mask before inversion: inactive level equals polarity bit
                    o_channel_out[c] <= (i_pwm_raw[c] & ~output_gate_register[c]) ^ polarity_reg[c];
                end
            end
        end
    end

    // ----------------------------------------
    // triggers
    // ----------------------------------------
    logic counter_clock_select_start;
    logic [channels-1:0] match_prev_reg; // match is a level; edge keeps the trigger one clock wide
    assign counter_clock_select_start = wr_en && i_paddr == ctrl_off && counter_clock_select == 2'h0 &&
                        i_pwdata[ctrl_counter_clock_select_pos +: 2] != 2'h0 && i_counter_at_initial;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_match_trigger  <= 1'b0;
            o_reload_trigger <= 1'b0;
            match_prev_reg   <= '0;
        end else begin
            match_prev_reg   <= i_channel_match;
            o_match_trigger  <= enhanced_features_enable && any_combined &&
                                |(trig_sel_reg & i_channel_match & ~match_prev_reg);
            o_reload_trigger <= reload_trigger_enable && any_combined &&
                                (i_counter_reload || i_counter_byte_write ||
                                 i_counter_sync || counter_clock_select_start);
        end
    end

    // ----------------------------------------
    // apb slave, zero wait states
    // ----------------------------------------
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_prdata  <= '0;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= 1'b0;
            o_prdata  <= '0;
            if (i_psel && !i_penable && !i_pwrite) begin
                case (i_paddr)
                    ctrl_off:      o_prdata <= ctrl_reg;
                    gate_off:      o_prdata <= 32'(output_gate_register);
                    polarity_off:  o_prdata <= 32'(polarity_reg);
                    init_off:      o_prdata <= 32'(init_value_reg);
                    trig_cfg_off:  o_prdata <= 32'(trig_sel_reg);
                    fault_cfg_off: o_prdata <= 32'(fault_input_enable) |
                                               (32'(fault_filter_enable) << fcfg_flt_pos) |
                                               (32'(fault_filter_length) << fcfg_len_pos);
                    fault_sts_off: o_prdata <= 32'(fault_input_flag) |
                                               (32'(fault_any_flag) << fsts_any_pos) |
                                               (32'(fault_level_status) << fsts_lvl_pos) |
                                               (32'(o_fault_irq) << fsts_irq_pos);
                    default:       o_pslverr <= i_psel && !i_penable;
                endcase
            end else if (i_psel && !i_penable && i_pwrite) begin
                if (!(i_paddr inside {ctrl_off, gate_off, polarity_off, init_off,
                                      trig_cfg_off, fault_cfg_off, fault_sts_off}))
                    o_pslverr <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_gate_forces_inactive: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (in_comb(combine_pair, 0) && !pair_safe_reg[0] && !init_cmd_reg && !init_hold_reg[0] &&
         output_gate_register[0]) |=> o_channel_out[0] == $past(polarity_reg[0]))
        else $error("masked channel not inactive");
    a_gate_sync_hold: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (gate_sync_enable && !i_gate_sync_trigger) |=> $stable(output_gate_register))
        else $error("mask changed without trigger");
    a_gate_direct: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        !gate_sync_enable |=> output_gate_register == $past(gate_buf_reg))
        else $error("mask not loaded from buffer");
    a_any_is_or: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        fault_rise[0] |=> fault_input_flag[0] && fault_any_flag)
        else $error("fault edge did not set flags");
    a_bypass_delay: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (fault_ctrl_on && fault_input_enable[0] && !filter_on[0] && !clear_write &&
         $rose(sync2_reg[0])) |=> fault_input_flag[0])
        else $error("bypass flag late");
    a_irq_follow: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (fault_any_flag && fault_irq_enable) |=> o_fault_irq)
        else $error("irq not raised");
    a_fault_safe: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (fault_ctrl_on && pair_fault_enable[0] && combine_pair[0] && |fault_rise)
        |=> pair_safe_reg[0] ##1 o_channel_out[0] == polarity_reg[0])
        else $error("pair not forced safe");
    a_no_fault_off: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        !fault_ctrl_on |=> pair_safe_reg == '0 && (fault_input_flag & ~$past(fault_input_flag)) == '0)
        else $error("fault acted while disabled");
    a_trig_pulse: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        o_match_trigger |-> $past(enhanced_features_enable) ##1 !o_match_trigger)
        else $error("match trigger not a single pulse");
    c_fault_seen: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) |pair_safe_reg);
    c_auto_clear: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
        $fell(pair_safe_reg[0]) && fault_handling_mode == fmode_auto);
    c_reload_trig: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) o_reload_trigger);
endmodule : pwm_output_fault_control
`default_nettype wire

// *** tb/fault_source.sv ***
`timescale 1ns/1ns
`default_nettype none
// --------------------
// fault pin source
// --------------------
module fault_source (
    input  wire logic       i_core_clk,
    input  wire logic [3:0] i_fire,
    input  wire logic [7:0] i_width,
    output logic      [3:0] o_fault_pin
);
    logic [7:0] left_reg = 8'h00;
    logic [3:0] pins_reg = 4'h0;
    // idle pins sit low, as their pull-downs would hold them
    always @(posedge i_core_clk) begin
        if (i_fire != 4'h0) begin
            pins_reg <= i_fire;
            left_reg <= i_width;
        end else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
    end
    assign o_fault_pin = (left_reg != 8'h00) ? pins_reg : 4'h0;
endmodule : fault_source
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import pwm_gate_pkg::*;
    // --------------------
    // design, source, bus
    // --------------------
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, err, irq, mtr, rtr, qe;
    logic [7:0] pa = 8'h00, wid = 8'h00;
    logic [31:0] pwd = 32'h0, prd, q;
    logic [5:0] raw = 6'h00, mat = 6'h00, out, ev = 6'h00;  // reload,byte,sync,gate,at initial,cycle
    logic [3:0] fire = 4'h0, fpin;
    int error_cnt = 0, check_count = 0, nm = 0, nr = 0;
    always #2 clk = ~clk;
    // non-blocking so a same-edge read sees a settled count
    always @(posedge clk) nm <= nm + int'(mtr === 1'b1);
    always @(posedge clk) nr <= nr + int'(rtr === 1'b1);
    pwm_output_fault_control dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
        .i_pwm_raw(raw), .i_channel_match(mat), .i_fault_pin(fpin), .i_cycle_start(ev[5]),
        .i_counter_reload(ev[0]), .i_counter_byte_write(ev[1]), .i_counter_sync(ev[2]),
        .i_gate_sync_trigger(ev[3]), .i_counter_at_initial(ev[4]), .o_channel_out(out),
        .o_fault_irq(irq), .o_match_trigger(mtr), .o_reload_trigger(rtr));
    fault_source src (.i_core_clk(clk), .i_fire(fire), .i_width(wid), .o_fault_pin(fpin));
    task automatic chk(input logic [31:0] g, e, input string m);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
        end
    endtask : chk
    // request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr  <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk) pen <= 1'b1;
        // no cycle limit here; the watchdog ends a hung bus
        do @(posedge clk); while (rdy !== 1'b1);
        q = prd;
        qe = err;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic flt(input logic [7:0] w);
        fire <= 4'h1;
        wid <= w;
        @(posedge clk) fire <= 4'h0;
        repeat (14) @(posedge clk);
    endtask : flt
    // inputs pulse one cycle, or stand through a control write
    task automatic pls(input logic [5:0] m, e, input logic [31:0] k, input int xm, xr);
        int a = nm, b = nr;
        mat <= m;
        ev <= e;
        if (k != 32'h0) apb(1'b1, ctrl_off, k);
        else @(posedge clk);
        mat <= 6'h00;
        ev <= 6'h00;
        repeat (4) @(posedge clk);
        chk(32'(nm - a), 32'(xm), "match trig");
        chk(32'(nr - b), 32'(xr), "reload trig");
    endtask : pls
    task automatic t_mask;
        apb(1'b1, ctrl_off, 32'h101);
        apb(1'b1, polarity_off, 32'h2);
        apb(1'b1, gate_off, 32'h1);
        raw <= 6'h3f;
        repeat (3) @(posedge clk);
        chk(32'(out), 32'h3c, "mask active");
        raw <= 6'h00;
        repeat (3) @(posedge clk);
        chk(32'(out), 32'h02, "mask idle");
        apb(1'b1, ctrl_off, 32'h109);
        apb(1'b1, gate_off, 32'h3);
        apb(1'b0, gate_off, 32'h0);
        chk(q, 32'h1, "mask buffered");
        pls(6'h00, 6'h08, 32'h0, 0, 0);
        apb(1'b0, gate_off, 32'h0);
        chk(q, 32'h3, "mask synced");
        apb(1'b1, ctrl_off, 32'h101);
        apb(1'b1, gate_off, 32'h0);
        $display("mask test done");
    endtask : t_mask
    task automatic t_fault;
        apb(1'b1, fault_cfg_off, 32'h1);
        apb(1'b1, polarity_off, 32'h1);
        raw <= 6'h3f;
        flt(8'h03);
        apb(1'b0, fault_sts_off, 32'h0);
        chk(q, 32'h0, "fault off");
        apb(1'b1, ctrl_off, 32'h1113);
        flt(8'h03);
        chk(32'(out), 32'h3d, "safe values");
        chk(32'(irq), 32'h1, "irq set");
        apb(1'b0, fault_sts_off, 32'h0);
        chk(q, 32'h51, "status");
        apb(1'b1, fault_sts_off, 32'h0);
        // irq is registered one clock behind the cleared flag
        @(posedge clk);
        chk(32'(irq), 32'h0, "irq clear");
        chk(32'(out), 32'h3d, "held");
        pls(6'h00, 6'h20, 32'h0, 0, 0);
        chk(32'(out), 32'h3e, "manual release");
        apb(1'b1, ctrl_off, 32'h1117);
        flt(8'h03);
        chk(32'(out), 32'h3d, "auto forced");
        pls(6'h00, 6'h20, 32'h0, 0, 0);
        chk(32'(out), 32'h3e, "auto release");
        apb(1'b0, fault_sts_off, 32'h0);
        apb(1'b1, fault_sts_off, 32'h0);
        $display("fault test done");
    endtask : t_fault
    task automatic t_filter;
        apb(1'b1, fault_cfg_off, 32'h411);
        flt(8'h02);
        apb(1'b0, fault_sts_off, 32'h0);
        chk(q, 32'h0, "glitch");
        flt(8'h0a);
        apb(1'b0, fault_sts_off, 32'h0);
        chk(q & 32'h1, 32'h1, "accepted");
        apb(1'b1, fault_sts_off, 32'h0);
        repeat (10) @(posedge clk);
        pls(6'h00, 6'h20, 32'h0, 0, 0);
        $display("filter test done");
    endtask : t_filter
    task automatic t_trig;
        apb(1'b1, trig_cfg_off, 32'h3f);
        apb(1'b1, ctrl_off, 32'h121);
        for (int j = 0; j < 6; j++) pls(6'(1 << j), 6'h00, 32'h0, 1, 0);
        apb(1'b1, trig_cfg_off, 32'h3e);
        pls(6'h01, 6'h00, 32'h0, 0, 0);
        for (int i = 0; i < 3; i++) pls(6'h00, 6'(1 << i), 32'h0, 0, 1);
        pls(6'h00, 6'h10, 32'h161, 0, 1);
        $display("trigger test done");
    endtask : t_trig
    task automatic t_init;
        apb(1'b1, ctrl_off, 32'h101);
        apb(1'b1, polarity_off, 32'h0);
        raw <= 6'h00;
        apb(1'b1, init_off, 32'h103);
        repeat (2) @(posedge clk);
        chk(32'(out), 32'h03, "init");
        apb(1'b0, init_off, 32'h0);
        chk(q, 32'h03, "init cmd");
        $display("init test done");
    endtask : t_init
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, ctrl_off, 32'h0);
        chk(q, reset_word, "ctrl reset");
        chk(32'(out), 32'h0, "out reset");
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(qe), 32'h1, "unmapped");
        $display("reset test done");
        t_mask();
        t_fault();
        t_filter();
        t_trig();
        t_init();
        final_report();
    end
    initial begin
        repeat (6000) @(posedge clk);
        error_cnt++;
        final_report();
    end
endmodule : testbench
`default_nettype wire
